// ---- hdl/sadc_pkg.sv ----
package sadc_pkg;
    // readout and conversion sequence
    localparam int         DATA_W       = 8;
    localparam logic [3:0] EDGE_SAMPLE  = 4'h4;
    localparam logic [3:0] EDGE_LAST    = 4'h8;
    localparam logic [5:0] HOLD_CYC     = 6'h04;
    localparam logic [5:0] CONV_CYC     = 6'h20;
    localparam logic [5:0] TOTAL_CYC    = 6'h24;
    localparam logic [1:0] SEL_QUAL_CYC = 2'h3;
    localparam logic [7:0] TRIAL_MSB    = 8'h80;
    localparam logic [7:0] RESULT_RST   = 8'h00;
    // timing: 4000 ps clock, 17 us conversion limit
    localparam int CLK_PERIOD_PS   = 32'h0000_0FA0;
    localparam int T_CONV_MAX_US   = 32'h0000_0011;
    localparam int PS_PER_US       = 32'h000F_4240;
    localparam int CONV_MAX_CYC    = (T_CONV_MAX_US * PS_PER_US) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {PH_IDLE, PH_QUAL, PH_ACCESS} sadc_phase_t;
    typedef enum logic [1:0] {CV_IDLE, CV_HOLD, CV_CONV} sadc_conv_t;

    typedef struct packed {
        logic [2:0] gray;
    } sadc_link_t;

    typedef struct packed {
        logic        sel_m;
        logic        sel_s;
        logic [2:0]  g_m;
        logic [2:0]  g_s;
        logic        cmp_m;
        logic        cmp_s;
        logic [2:0]  last;
        sadc_phase_t ph;
        logic [1:0]  qual;
        logic [3:0]  bit_idx;
        logic [7:0]  shreg;
        logic        data_out;
        sadc_conv_t  cv;
        logic [5:0]  cv_cnt;
        logic [7:0]  trial;
        logic [7:0]  result;
        logic        sample_en;
        logic        hold_en;
        logic        busy;
    } sadc_sys_t;

    function automatic logic [2:0] gray2bin(input logic [2:0] g);
        logic [2:0] b;
        b[2] = g[2];
        for (int i = 1; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic [2:0] bin2gray(input logic [2:0] b);
        return b ^ (b >> 1);
    endfunction
endpackage

// ---- hdl/sadc_top.sv ----
`timescale 1ns/1ps
module sadc_top #(
    parameter int CONV_MAX_CYC = sadc_pkg::CONV_MAX_CYC
) (
    // system
    input  wire logic       clk,
    input  wire logic       reset,
    // serial link
    input  wire logic       io_clk,
    input  wire logic       select_n,
    output logic            data_out,
    output logic            data_oe,
    // analog front end
    input  wire logic       cmp_high,
    output logic [7:0]      dac_code,
    output logic            sample_en,
    output logic            hold_en,
    output logic            busy
);

    sadc_pkg::sadc_link_t l;
    sadc_pkg::sadc_link_t next_l;
    sadc_pkg::sadc_sys_t  s;
    sadc_pkg::sadc_sys_t  next_s;
    logic [2:0]           bin_now;
    logic [7:0]           mask;
    logic [7:0]           dec;
    logic                 edge_seen;
    logic                 start_cv;
    logic                 conv_fin;
    logic                 oe_clr;
    logic [12:0]          age;

    // link domain: gray count of falling shift edges
    // own clock
    always_comb begin
        next_l      = l;
        next_l.gray = sadc_pkg::bin2gray(3'(sadc_pkg::gray2bin(l.gray) + 3'h1));
    end

    always_ff @(negedge io_clk or posedge reset) begin
        if (reset) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // system domain
    always_comb begin
        next_s    = s;
        edge_seen = 1'b0;
        start_cv  = 1'b0;
        conv_fin  = 1'b0;
        mask      = '0;
        dec       = '0;
        bin_now   = sadc_pkg::gray2bin(s.g_s);

        next_s.sel_m = select_n;
        next_s.sel_s = s.sel_m;
        next_s.g_m   = l.gray;
        next_s.g_s   = s.g_m;
        next_s.cmp_m = cmp_high;
        next_s.cmp_s = s.cmp_m;

        unique case (s.cv)
            sadc_pkg::CV_IDLE: begin
                next_s.cv_cnt = '0;
            end
            sadc_pkg::CV_HOLD: begin
                next_s.cv_cnt = 6'(s.cv_cnt + 6'h01);
                if (s.cv_cnt == 6'(sadc_pkg::HOLD_CYC - 6'h01)) begin
                    next_s.cv     = sadc_pkg::CV_CONV;
                    next_s.cv_cnt = '0;
                    next_s.trial  = sadc_pkg::TRIAL_MSB;
                end
            end
            sadc_pkg::CV_CONV: begin
                mask          = sadc_pkg::TRIAL_MSB >> s.cv_cnt[4:2];
                next_s.cv_cnt = 6'(s.cv_cnt + 6'h01);
                if (s.cv_cnt[1:0] == 2'h3) begin
                    dec = s.cmp_s ? s.trial : (s.trial & ~mask);
                    if (s.cv_cnt == 6'(sadc_pkg::CONV_CYC - 6'h01)) begin
                        conv_fin       = 1'b1;
                        next_s.result  = dec;
                        next_s.trial   = dec;
                        next_s.cv      = sadc_pkg::CV_IDLE;
                        next_s.busy    = 1'b0;
                        next_s.hold_en = 1'b0;
                        if (s.ph == sadc_pkg::PH_ACCESS && s.bit_idx == 4'h0) begin
                            next_s.shreg    = dec;
                            next_s.data_out = dec[7];
                        end
                    end else begin
                        next_s.trial = dec | (mask >> 1);
                    end
                end
            end
            default: begin
                next_s.cv = sadc_pkg::CV_IDLE;
            end
        endcase

        unique case (s.ph)
            sadc_pkg::PH_IDLE: begin
                next_s.last = bin_now;
                if (!s.sel_s) begin
                    next_s.ph   = sadc_pkg::PH_QUAL;
                    next_s.qual = '0;
                end
            end
            sadc_pkg::PH_QUAL: begin
                next_s.last = bin_now;
                if (s.sel_s) begin
                    next_s.ph = sadc_pkg::PH_IDLE;
                end else if (s.qual == 2'(sadc_pkg::SEL_QUAL_CYC - 2'h1)) begin
                    next_s.ph       = sadc_pkg::PH_ACCESS;
                    next_s.bit_idx  = '0;
                    next_s.shreg    = s.result;
                    next_s.data_out = s.result[7];
                    next_s.cv        = sadc_pkg::CV_IDLE;
                    next_s.busy      = 1'b0;
                    next_s.hold_en   = 1'b0;
                    next_s.sample_en = 1'b0;
                end else begin
                    next_s.qual = 2'(s.qual + 2'h1);
                end
            end
            sadc_pkg::PH_ACCESS: begin
                if (s.sel_s) begin
                    next_s.ph        = sadc_pkg::PH_IDLE;
                    next_s.sample_en = 1'b0;
                    next_s.last      = bin_now;
                end else if (bin_now != s.last) begin
                    edge_seen   = 1'b1;
                    next_s.last = 3'(s.last + 3'h1);
                    if (s.bit_idx == 4'(sadc_pkg::EDGE_LAST - 4'h1)) begin
                        // next access follows with select low
                        start_cv         = 1'b1;
                        next_s.bit_idx   = '0;
                        next_s.sample_en = 1'b0;
                        next_s.cv        = sadc_pkg::CV_HOLD;
                        next_s.cv_cnt    = '0;
                        next_s.busy      = 1'b1;
                        next_s.hold_en   = 1'b1;
                        next_s.shreg     = s.result;
                        next_s.data_out  = s.result[7];
                    end else begin
                        next_s.bit_idx  = 4'(s.bit_idx + 4'h1);
                        next_s.shreg    = {s.shreg[6:0], 1'b0};
                        next_s.data_out = s.shreg[6];
                        if (s.bit_idx == 4'(sadc_pkg::EDGE_SAMPLE - 4'h1)) begin
                            next_s.sample_en = 1'b1;
                        end
                    end
                end
            end
            default: begin
                next_s.ph = sadc_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s        <= '0;
            s.sel_m  <= 1'b1;
            s.sel_s  <= 1'b1;
            s.result <= sadc_pkg::RESULT_RST;
        end else begin
            s <= next_s;
        end
    end

    // output released at once by raw select
    assign oe_clr = reset | select_n;

    always_ff @(posedge clk or posedge oe_clr) begin
        if (oe_clr) begin
            data_oe <= 1'b0;
        end else begin
            data_oe <= (next_s.ph == sadc_pkg::PH_ACCESS);
        end
    end

    assign data_out  = s.data_out;
    assign dac_code  = s.trial;
    assign sample_en = s.sample_en;
    assign hold_en   = s.hold_en;
    assign busy      = s.busy;

    // cycles since conversion start, checked below
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            age <= '0;
        end else if (start_cv) begin
            age <= '0;
        end else if (s.busy) begin
            age <= 13'(age + 13'h0001);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence sel_fall_settle;
        $fell(s.sel_s) ##1 (!s.sel_s) [*3];
    endsequence

    sequence hold_phase;
        (s.cv == sadc_pkg::CV_HOLD && s.busy && hold_en) [*4];
    endsequence

    sequence conv_entry;
        s.cv == sadc_pkg::CV_CONV && s.cv_cnt == 6'h00 && dac_code == sadc_pkg::TRIAL_MSB;
    endsequence

    deselect_quiet_a: assert property (s.sel_s |-> !data_oe)
        else $error("output enabled while deselected");

    idle_ignore_a: assert property (s.ph == sadc_pkg::PH_IDLE |=> $stable(data_out))
        else $error("data changed while deselected");

    select_settle_a: assert property (
        sel_fall_settle |-> !data_oe ##1 (data_oe || s.sel_s || select_n))
        else $error("select settling time wrong");

    msb_first_a: assert property ($rose(data_oe) |-> data_out == $past(s.result[7]))
        else $error("first bit is not previous MSB");

    shift_bit_a: assert property (
        edge_seen && s.bit_idx < 4'h7 |=> data_out == $past(s.shreg[6]))
        else $error("wrong bit shifted out");

    sample_open_a: assert property (
        edge_seen && s.bit_idx == 4'h3 |=> sample_en && s.bit_idx == 4'h4)
        else $error("sampling did not start at fourth edge");

    sample_window_a: assert property (
        sample_en |-> s.bit_idx >= 4'h4 && s.bit_idx <= 4'h7)
        else $error("sampling outside acquisition window");

    hold_then_conv_a: assert property (start_cv |=> hold_phase ##1 conv_entry)
        else $error("hold phase not four cycles");

    conv_total_a: assert property (conv_fin |-> age == 13'(sadc_pkg::TOTAL_CYC - 6'h01))
        else $error("conversion not 36 cycles");

    conv_limit_a: assert property (busy |-> age < 13'(CONV_MAX_CYC))
        else $error("conversion exceeds time limit");

    abort_a: assert property (
        $past(s.ph) == sadc_pkg::PH_QUAL && s.ph == sadc_pkg::PH_ACCESS |-> !busy && !hold_en)
        else $error("conversion not aborted by select");

    restart_a: assert property (
        edge_seen && s.bit_idx == 4'h7 |=> busy && s.cv_cnt == 6'h00
            && data_out == $past(s.result[7]))
        else $error("restart did not deliver older result");

    result_keep_a: assert property (
        s.result != $past(s.result) |-> $past(conv_fin))
        else $error("result changed without completed conversion");

endmodule

// ---- verification/sadc_host.sv ----
`timescale 1ns/1ps
module sadc_host #(
    parameter real HALF_NS = 62.5
) (
    // link to the device
    output logic      io_clk,
    output logic      select_n,
    input  wire logic data_line,
    // sampling probe
    input  wire logic probe
);
    initial begin
        io_clk   = 1'b0;
        select_n = 1'b1;
    end

    task automatic access(input bit keep_low, output logic [7:0] got,
                          output logic [7:0] smp);
        select_n = 1'b0;
        #(100.0);
        got[7] = data_line;
        for (int k = 1; k <= 8; k++) begin
            io_clk = 1'b1;
            #(HALF_NS);
            io_clk = 1'b0;
            #(HALF_NS);
            smp[8 - k] = probe;
            if (k < 8) got[7 - k] = data_line;
        end
        if (!keep_low) select_n = 1'b1;
    endtask

    task automatic stray(input int n);
        for (int k = 0; k < n; k++) begin
            io_clk = 1'b1;
            #(HALF_NS);
            io_clk = 1'b0;
            #(HALF_NS);
        end
    endtask

    task automatic abort_pulse();
        #(8.0);
        select_n = 1'b0;
        #(40.0);
        select_n = 1'b1;
    endtask
endmodule

// ---- verification/sadc_top_test.sv ----
`timescale 1ns/1ps
module sadc_top_test;
    logic       clk;
    logic       reset;
    logic       cmp_high;
    logic [7:0] ain;
    wire        io_clk;
    wire        select_n;
    wire        data_out;
    wire        data_oe;
    wire        data_line;
    wire [7:0]  dac_code;
    wire        sample_en;
    wire        hold_en;
    wire        busy;
    int         n_errors;
    int         comparisons;
    int         run;
    int         last_run;
    logic [7:0] got;
    logic [7:0] smp;

    sadc_top dut (.clk(clk), .reset(reset), .io_clk(io_clk), .select_n(select_n),
        .data_out(data_out), .data_oe(data_oe), .cmp_high(cmp_high),
        .dac_code(dac_code), .sample_en(sample_en), .hold_en(hold_en), .busy(busy));
    sadc_host host (.io_clk(io_clk), .select_n(select_n), .data_line(data_line),
        .probe(sample_en));

    assign data_line = data_oe ? data_out : 1'bz;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // comparator of the analog input against the trial code
    always @(negedge clk) begin
        cmp_high <= (ain >= dac_code);
    end

    // length of each hold plus convert run
    always @(posedge clk) begin
        if (busy === 1'b1 && hold_en === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            last_run <= run;
            run      <= 0;
        end
    end

    task automatic chk_bit(input string what, input logic exp, input logic seen);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic chk_byte(input string what, input logic [7:0] exp,
                            input logic [7:0] seen);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic read_prev(input bit keep_low, input logic [7:0] exp);
        host.access(keep_low, got, smp);
        chk_byte("readout", exp, got);
        chk_byte("sample window", 8'h1E, smp);
        chk_bit("busy after last edge", 1'b1, busy);
        if (!keep_low) begin
            #1;
            chk_bit("oe on release", 1'b0, data_oe);
            chk_bit("line on release", 1'bz, data_line);
        end
    endtask

    task automatic wait_done(input logic [7:0] exp);
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        chk_byte("hold plus convert", 8'h24, 8'(last_run));
        chk_byte("final code", exp, dac_code);
    endtask

    task automatic t_reset();
        chk_bit("oe at reset", 1'b0, data_oe);
        chk_bit("busy at reset", 1'b0, busy);
        chk_byte("code at reset", 8'h00, dac_code);
    endtask

    task automatic t_full_scale();
        ain = 8'hFF;
        read_prev(1'b0, 8'h00);
        wait_done(8'hFF);
    endtask

    task automatic t_shared_clock();
        host.stray(8);
        chk_bit("oe deselected", 1'b0, data_oe);
        chk_bit("line deselected", 1'bz, data_line);
        ain = 8'h00;
        read_prev(1'b0, 8'hFF);
        wait_done(8'h00);
    endtask

    task automatic t_back_to_back();
        ain = 8'hA5;
        read_prev(1'b1, 8'h00);
        wait_done(8'hA5);
        read_prev(1'b0, 8'hA5);
        wait_done(8'hA5);
    endtask

    task automatic t_abort();
        ain = 8'h3C;
        read_prev(1'b0, 8'hA5);
        host.abort_pulse();
        #40;
        chk_bit("busy after abort", 1'b0, busy);
        #200;
        read_prev(1'b0, 8'hA5);
        wait_done(8'h3C);
        read_prev(1'b0, 8'h3C);
        wait_done(8'h3C);
    endtask

    initial begin
        n_errors    = 0;
        comparisons = 0;
        run         = 0;
        last_run    = 0;
        ain         = 8'h00;
        cmp_high    = 1'b0;
        reset       = 1'b1;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        t_reset();
        t_full_scale();
        t_shared_clock();
        t_back_to_back();
        t_abort();
        summarize();
    end

    initial begin
        #50000;
        n_errors++;
        summarize();
    end
endmodule
